// [include/pdpc_defines.svh]
// constants of the positioning drive parameter core: entry indices, reset values, timing
// assumes a 25 MHz clock and an object-dictionary access port of index plus data
`ifndef PDPC_DEFINES_SVH
`define PDPC_DEFINES_SVH
`define PDPC_IDX_GP 16'h2000
`define PDPC_IDX_TGT 16'h2001
`define PDPC_IDX_ACT 16'h2003
`define PDPC_IDX_OFS 16'h2004
`define PDPC_IDX_FERR 16'h2005
`define PDPC_IDX_WIN 16'h2006
`define PDPC_IDX_NUM 16'h2010
`define PDPC_IDX_DEN 16'h2011
`define PDPC_IDX_SPD_AUTO 16'h2012
`define PDPC_IDX_SPD_HAND 16'h2013
`define PDPC_IDX_TRQ_RUN 16'h2014
`define PDPC_IDX_HI 16'h2016
`define PDPC_IDX_LO 16'h2017
`define PDPC_IDX_TRQ_START 16'h2018
`define PDPC_IDX_START_T 16'h2019
`define PDPC_IDX_STALL_PCT 16'h201A
`define PDPC_IDX_STALL_T 16'h201B
`define PDPC_IDX_RAMP_UP 16'h201C
`define PDPC_IDX_RAMP_DN 16'h201D
`define PDPC_IDX_LOOP 16'h201F
`define PDPC_IDX_CCW 16'h2020
`define PDPC_IDX_CW 16'h2021
`define PDPC_IDX_STEP 16'h2022
`define PDPC_IDX_HOLD 16'h2023
`define PDPC_IDX_CTRL 16'h2024
`define PDPC_IDX_STAT 16'h2025
`define PDPC_GP_WORDS 10
`define PDPC_RST_FERR 16'h0028
`define PDPC_RST_WIN 16'h0002
`define PDPC_RST_NUM 16'h0190
`define PDPC_RST_DEN 16'h0190
`define PDPC_RST_HI 32'h00018B50
`define PDPC_RST_LO 32'h000004B0
`define PDPC_RST_START_T 16'h00C8
`define PDPC_RST_STALL_PCT 16'h001E
`define PDPC_RST_STALL_T 16'h00C8
`define PDPC_RST_LOOP 32'h000000FA
`define PDPC_RST_STEP 16'h0001
`define PDPC_RST_HOLD 16'h00C8
`define PDPC_FERR_UNIT 32'h00000032
`define PDPC_CLK_HZ 25000000
`define PDPC_MS_CYC ((`PDPC_CLK_HZ + 999) / 1000)
`define PDPC_HOLD_STEP_MS 5
`define PDPC_CB_MAN_UP 0
`define PDPC_CB_MAN_DN 1
`define PDPC_CB_JOG_UP 8
`define PDPC_CB_JOG_DN 9
`define PDPC_SB_REACHED 0
`define PDPC_SB_FERR 1
`define PDPC_SB_ABORT 5
`define PDPC_SB_RUN 6
`define PDPC_SB_BAD_TGT 12
`endif

// [include/pdpc_pkg.sv]
// types of the positioning drive parameter core
// assumes the defines header is included by users of numbers
package pdpc_pkg;
  typedef enum logic [4:0] {
    PDPC_IDLE = 5'h01,
    PDPC_LOOP = 5'h02,
    PDPC_AUTO = 5'h04,
    PDPC_STEP = 5'h08,
    PDPC_HAND = 5'h10
  } pdpc_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [3:0] sub;
    logic [31:0] data;
  } pdpc_req_t;
  typedef struct packed {
    logic [15:0] speed_limit;
    logic [15:0] torque_limit;
    logic [15:0] ramp_rate;
    logic dir_up;
    logic run;
  } pdpc_drive_t;
endpackage : pdpc_pkg

// [logic/pdpc_core.sv]
// parameter and motion core: object dictionary entries, limits, windows, run sequencing
// assumes a fieldbus stack presents single-cycle entry accesses and an encoder count
`timescale 1ns/1ps
`include "pdpc_defines.svh"
module pdpc_core
  import pdpc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pdpc_req_t req,
  output logic [31:0] rd_data,
  output logic rd_err,
  input wire logic nv_load,
  input wire logic [31:0] enc_count,
  input wire logic enc_tick,
  input wire logic [15:0] speed_meas,
  input wire logic [15:0] speed_cmd,
  input wire logic key_up,
  input wire logic key_dn,
  output pdpc_drive_t drive,
  output logic [15:0] status_word
);
  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction : absdiff
  function automatic logic [31:0] ms_cycles(input logic [15:0] ms);
    ms_cycles = 32'(ms) * 32'(`PDPC_MS_CYC);
  endfunction : ms_cycles

  // ********************
  // key synchronisers
  // ********************
  logic [2:0] kup_q, kdn_q;
  logic kup_s_q, kdn_s_q;
  always_ff @(posedge clk) begin
    kup_q <= {kup_q[1:0], key_up};
    kdn_q <= {kdn_q[1:0], key_dn};
    if (kup_q[1] == kup_q[2]) kup_s_q <= kup_q[2];
    if (kdn_q[1] == kdn_q[2]) kdn_s_q <= kdn_q[2];
  end

  // ********************
  // registers
  // ********************
  logic [15:0] gp_q [`PDPC_GP_WORDS];
  logic [31:0] tgt_q, ofs_q, hi_q, lo_q, loop_q, ref_q;
  logic [15:0] ferr_q, win_q, num_q, den_q, spd_auto_q, spd_hand_q, trq_run_q, trq_start_q;
  logic [15:0] start_t_q, stall_pct_q, stall_t_q, up_q, dn_q, ccw_q, cw_q, step_q, hold_q;
  logic [15:0] ctrl_q;
  wire logic wr = req.wr;
  wire logic hit_gp = req.index == `PDPC_IDX_GP && req.sub < 4'(`PDPC_GP_WORDS);
  // user position = raw * den / num + offset
  wire logic [63:0] scaled = 64'($signed(enc_count - ref_q)) * 64'(den_q);
  wire logic [31:0] raw_user = 32'($signed(scaled) / $signed({48'h0, num_q}));
  wire logic [31:0] act_user = raw_user + ofs_q;
  wire logic [31:0] tgt_eff = tgt_q + ofs_q;
  wire logic [31:0] hi_eff = hi_q + ofs_q;
  wire logic [31:0] lo_eff = lo_q + ofs_q;
  wire logic [63:0] ref_scaled = 64'($signed(req.data - ofs_q)) * 64'(num_q);
  wire logic [31:0] ref_new = enc_count - 32'($signed(ref_scaled) / $signed({48'h0, den_q}));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tgt_q <= 32'h0;
      ctrl_q <= 16'h0;
      ref_q <= 32'h0;
    end else begin
      if (wr && req.index == `PDPC_IDX_TGT) tgt_q <= req.data;
      if (wr && req.index == `PDPC_IDX_CTRL) ctrl_q <= req.data[15:0];
      if (wr && req.index == `PDPC_IDX_ACT) ref_q <= ref_new;
    end
  end

  // retained entries reload from storage defaults on power-up load
  always_ff @(posedge clk) begin
    if (sys_rst || nv_load) begin
      for (int i = 0; i < `PDPC_GP_WORDS; i++) gp_q[i] <= 16'h0;
      ofs_q <= 32'h0;
      ferr_q <= `PDPC_RST_FERR;
      win_q <= `PDPC_RST_WIN;
      num_q <= `PDPC_RST_NUM;
      den_q <= `PDPC_RST_DEN;
      spd_auto_q <= 16'h0;
      spd_hand_q <= 16'h0;
      trq_run_q <= 16'h0;
      hi_q <= `PDPC_RST_HI;
      lo_q <= `PDPC_RST_LO;
      trq_start_q <= 16'h0;
      start_t_q <= `PDPC_RST_START_T;
      stall_pct_q <= `PDPC_RST_STALL_PCT;
      stall_t_q <= `PDPC_RST_STALL_T;
      up_q <= 16'h0;
      dn_q <= 16'h0;
      loop_q <= `PDPC_RST_LOOP;
      ccw_q <= 16'h0;
      cw_q <= 16'h0;
      step_q <= `PDPC_RST_STEP;
      hold_q <= `PDPC_RST_HOLD;
    end else if (wr) begin
      if (hit_gp) gp_q[req.sub] <= req.data[15:0];
      case (req.index)
        `PDPC_IDX_OFS: ofs_q <= req.data;
        `PDPC_IDX_FERR: ferr_q <= req.data[15:0];
        `PDPC_IDX_WIN: win_q <= req.data[15:0];
        `PDPC_IDX_NUM: num_q <= req.data[15:0];
        `PDPC_IDX_DEN: den_q <= req.data[15:0];
        `PDPC_IDX_SPD_AUTO: spd_auto_q <= req.data[15:0];
        `PDPC_IDX_SPD_HAND: spd_hand_q <= req.data[15:0];
        `PDPC_IDX_TRQ_RUN: trq_run_q <= req.data[15:0];
        `PDPC_IDX_HI: hi_q <= req.data;
        `PDPC_IDX_LO: lo_q <= req.data;
        `PDPC_IDX_TRQ_START: trq_start_q <= req.data[15:0];
        `PDPC_IDX_START_T: start_t_q <= req.data[15:0];
        `PDPC_IDX_STALL_PCT: stall_pct_q <= req.data[15:0];
        `PDPC_IDX_STALL_T: stall_t_q <= req.data[15:0];
        `PDPC_IDX_RAMP_UP: up_q <= req.data[15:0];
        `PDPC_IDX_RAMP_DN: dn_q <= req.data[15:0];
        `PDPC_IDX_LOOP: loop_q <= req.data;
        `PDPC_IDX_CCW: ccw_q <= req.data[15:0];
        `PDPC_IDX_CW: cw_q <= req.data[15:0];
        `PDPC_IDX_STEP: step_q <= req.data[15:0];
        `PDPC_IDX_HOLD: hold_q <= req.data[15:0];
        default: ;
      endcase
    end
  end

  // ********************
  // monitors
  // ********************
  wire logic [31:0] dev = absdiff(tgt_eff, act_user);
  wire logic [31:0] ferr_lim = 32'(ferr_q) * `PDPC_FERR_UNIT;
  wire logic reached = dev <= 32'(win_q);
  wire logic tgt_hi = $signed(tgt_eff) > $signed(hi_eff);
  wire logic tgt_lo = $signed(tgt_eff) < $signed(lo_eff);
  wire logic tgt_bad = tgt_hi || tgt_lo;
  wire logic [31:0] stall_thr = (32'(speed_cmd) * 32'(stall_pct_q)) / 32'd100;
  wire logic slow = 32'(speed_meas) < stall_thr;

  // ********************
  // run sequencer
  // ********************
  pdpc_state_t st_q;
  logic [31:0] run_t_q, stall_c_q, hold_c_q, aim_q;
  logic aborted_q, ferr_flag_q, dir_q;
  wire logic ctl_up = ctrl_q[`PDPC_CB_MAN_UP] | ctrl_q[`PDPC_CB_JOG_UP] | kup_s_q;
  wire logic ctl_dn = ctrl_q[`PDPC_CB_MAN_DN] | ctrl_q[`PDPC_CB_JOG_DN] | kdn_s_q;
  wire logic manual_req = ctl_up ^ ctl_dn;
  wire logic [31:0] hold_lim = ms_cycles(16'(hold_q * 16'(`PDPC_HOLD_STEP_MS)));
  // judge the incoming target, not the stored one it replaces
  wire logic [31:0] new_tgt = req.data + ofs_q;
  wire logic new_hi = $signed(new_tgt) > $signed(hi_eff);
  wire logic new_lo = $signed(new_tgt) < $signed(lo_eff);
  wire logic start_go = wr && req.index == `PDPC_IDX_TGT && !new_hi && !new_lo;
  wire logic need_loop = loop_q != 32'h0 && $signed(req.data + ofs_q) < $signed(act_user);
  wire logic running = st_q != PDPC_IDLE;
  wire logic at_aim = absdiff(aim_q, act_user) <= 32'(win_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= PDPC_IDLE;
      run_t_q <= 32'h0;
      stall_c_q <= 32'h0;
      hold_c_q <= 32'h0;
      aim_q <= 32'h0;
      aborted_q <= 1'b0;
      ferr_flag_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      ferr_flag_q <= running && dev > ferr_lim;
      run_t_q <= running ? run_t_q + 32'h1 : 32'h0;
      stall_c_q <= (running && slow) ? stall_c_q + 32'h1 : 32'h0;
      hold_c_q <= manual_req ? hold_c_q + 32'h1 : 32'h0;
      case (st_q)
        PDPC_IDLE: begin
          if (start_go) begin
            aborted_q <= 1'b0;
            // loop first undershoots so final approach is always upward
            aim_q <= need_loop ? req.data + ofs_q - loop_q : req.data + ofs_q;
            st_q <= need_loop ? PDPC_LOOP : PDPC_AUTO;
          end else if (manual_req && hold_c_q == 32'h0) begin
            aim_q <= ctl_up ? act_user + 32'(step_q) : act_user - 32'(step_q);
            dir_q <= ctl_up;
            st_q <= PDPC_STEP;
          end
        end
        PDPC_LOOP: if (at_aim) begin
          aim_q <= tgt_eff;
          st_q <= PDPC_AUTO;
        end
        PDPC_AUTO: if (reached) st_q <= PDPC_IDLE;
        PDPC_STEP: begin
          if (manual_req && hold_c_q >= hold_lim) st_q <= PDPC_HAND;
          else if (at_aim && !manual_req) st_q <= PDPC_IDLE;
        end
        PDPC_HAND: if (!manual_req) st_q <= PDPC_IDLE;
        default: st_q <= PDPC_IDLE;
      endcase
      if (running && stall_c_q >= ms_cycles(stall_t_q)) begin
        st_q <= PDPC_IDLE;
        aborted_q <= 1'b1;
      end
    end
  end

  // ********************
  // drive outputs
  // ********************
  wire logic is_hand = st_q == PDPC_HAND || st_q == PDPC_STEP;
  wire logic go_up = is_hand ? dir_q : $signed(aim_q) > $signed(act_user);
  wire logic [15:0] dir_lim = go_up ? cw_q : ccw_q;
  wire logic [15:0] mode_lim = is_hand ? spd_hand_q : spd_auto_q;
  wire logic in_start = run_t_q < ms_cycles(start_t_q);
  wire logic near_aim = absdiff(aim_q, act_user) <= loop_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive <= '0;
      status_word <= 16'h0;
    end else begin
      drive.speed_limit <= (mode_lim < dir_lim) ? mode_lim : dir_lim;
      drive.torque_limit <= in_start ? trq_start_q : trq_run_q;
      drive.ramp_rate <= near_aim ? dn_q : up_q;
      drive.dir_up <= go_up;
      drive.run <= running;
      status_word <= '0;
      status_word[`PDPC_SB_REACHED] <= reached && !running;
      status_word[`PDPC_SB_FERR] <= ferr_flag_q;
      status_word[`PDPC_SB_ABORT] <= aborted_q;
      status_word[`PDPC_SB_RUN] <= running;
      status_word[`PDPC_SB_BAD_TGT] <= tgt_bad;
    end
  end

  // ********************
  // read mux
  // ********************
  logic [31:0] rmux;
  logic rbad;
  always_comb begin
    rbad = 1'b0;
    case (req.index)
      `PDPC_IDX_GP: begin
        rmux = hit_gp ? {16'h0, gp_q[req.sub]} : 32'h0;
        rbad = !hit_gp;
      end
      `PDPC_IDX_TGT: rmux = tgt_q;
      `PDPC_IDX_ACT: rmux = act_user;
      `PDPC_IDX_OFS: rmux = ofs_q;
      `PDPC_IDX_FERR: rmux = {16'h0, ferr_q};
      `PDPC_IDX_WIN: rmux = {16'h0, win_q};
      `PDPC_IDX_NUM: rmux = {16'h0, num_q};
      `PDPC_IDX_DEN: rmux = {16'h0, den_q};
      `PDPC_IDX_SPD_AUTO: rmux = {16'h0, spd_auto_q};
      `PDPC_IDX_SPD_HAND: rmux = {16'h0, spd_hand_q};
      `PDPC_IDX_TRQ_RUN: rmux = {16'h0, trq_run_q};
      `PDPC_IDX_HI: rmux = hi_q;
      `PDPC_IDX_LO: rmux = lo_q;
      `PDPC_IDX_TRQ_START: rmux = {16'h0, trq_start_q};
      `PDPC_IDX_START_T: rmux = {16'h0, start_t_q};
      `PDPC_IDX_STALL_PCT: rmux = {16'h0, stall_pct_q};
      `PDPC_IDX_STALL_T: rmux = {16'h0, stall_t_q};
      `PDPC_IDX_RAMP_UP: rmux = {16'h0, up_q};
      `PDPC_IDX_RAMP_DN: rmux = {16'h0, dn_q};
      `PDPC_IDX_LOOP: rmux = loop_q;
      `PDPC_IDX_CCW: rmux = {16'h0, ccw_q};
      `PDPC_IDX_CW: rmux = {16'h0, cw_q};
      `PDPC_IDX_STEP: rmux = {16'h0, step_q};
      `PDPC_IDX_HOLD: rmux = {16'h0, hold_q};
      `PDPC_IDX_CTRL: rmux = {16'h0, ctrl_q};
      `PDPC_IDX_STAT: rmux = {16'h0, status_word};
      default: begin
        rmux = 32'h0;
        rbad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 32'h0;
      rd_err <= 1'b0;
    end else if (req.rd) begin
      rd_data <= rmux;
      rd_err <= rbad;
    end
  end
endmodule : pdpc_core

// [testbench/pdpc_core_asserts.sv]
// checker of the parameter core: entry access, status bits, target limits
// assumes binding into pdpc_core with pdpc_pkg compiled first
`timescale 1ns/1ps
module pdpc_core_asserts
  import pdpc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pdpc_req_t req,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic nv_load,
  input wire logic [15:0] status_word
);
  // ***
  // limit shadow and properties
  // ***
  logic signed [31:0] hi_q;
  logic signed [31:0] lo_q;
  logic [15:0] wlo;
  wire tw = req.wr && req.index == 16'h2001;
  wire bad = $signed(req.data) > hi_q || $signed(req.data) < lo_q;
  assign wlo = req.data[15:0];
  always_ff @(posedge clk) begin
    if (sys_rst || nv_load) begin
      hi_q <= 32'h00018B50;
    end else if (req.wr && req.index == 16'h2016) begin
      hi_q <= req.data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || nv_load) begin
      lo_q <= 32'h000004B0;
    end else if (req.wr && req.index == 16'h2017) begin
      lo_q <= req.data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_GP_RT: assert property ((req.wr && req.index == 16'h2000 && req.sub < 4'hA) ##2
    (req.rd && req.index == 16'h2000 && req.sub == $past(req.sub, 2)) |=>
    rd_data == {16'h0000, $past(wlo, 3)})
    else $error("general word read back differs");
  AST_GP_SUB: assert property (req.rd && req.index == 16'h2000 && req.sub > 4'h9
    |=> rd_err && rd_data == 32'h0)
    else $error("bad subindex not refused");
  AST_RD_UNK: assert property (req.rd && req.index inside {16'h2002, 16'h2007, 16'h201E}
    |=> rd_err && rd_data == 32'h0)
    else $error("unknown entry not refused");
  AST_RD_OK: assert property (req.rd && req.index inside {16'h2005, 16'h2016, 16'h2025}
    |=> !rd_err)
    else $error("known entry refused");
  AST_RD_HOLD: assert property (!req.rd |=> $stable(rd_data) && $stable(rd_err))
    else $error("read result moved without read");
  AST_STAT_RSV: assert property ((status_word & 16'hEF9C) == 16'h0000)
    else $error("unused status bit set");
  AST_REACH_IDLE: assert property (!(status_word[0] && status_word[6]))
    else $error("reached while running");
  AST_BAD_TGT: assert property (tw && bad && !status_word[6]
    |-> ##[1:6] (status_word[12] && !status_word[6]))
    else $error("out of limit target not flagged");
endmodule : pdpc_core_asserts
bind pdpc_core pdpc_core_asserts pdpc_core_asserts_inst (.clk(clk), .sys_rst(sys_rst),
  .req(req), .rd_data(rd_data), .rd_err(rd_err), .nv_load(nv_load),
  .status_word(status_word));

// [testbench/pdpc_master.sv]
// fieldbus master model: one entry read or write per call
// assumes pdpc_pkg compiled first and rd_data valid one edge after rd
`timescale 1ns/1ps
module pdpc_master
  import pdpc_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  output pdpc_req_t req
);
  // ***
  // access task
  // ***
  initial req = '0;
  task automatic acc(input logic w, input logic [15:0] i, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk) #1;
    req = '{wr: w, rd: !w, index: i, sub: s, data: d};
    @(posedge clk) #1;
    req = '0;
    q = rd_data;
    e = rd_err;
  endtask : acc
endmodule : pdpc_master

// [testbench/test_positioning_drive_parameter_core.sv]
// self-checking bench of the parameter core: entries, limits, runs, stall
// assumes pdpc_pkg, the master model and the checker compiled first
`timescale 1ns/1ps
module test_positioning_drive_parameter_core
  import pdpc_pkg::*;
;
  // ***
  // stimulus and checks
  // ***
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic nv_load = 1'b0;
  logic [31:0] enc_count = 32'h00001000;
  logic [15:0] speed_meas = 16'h0000;
  logic [15:0] speed_cmd = 16'h0000;
  logic key_up = 1'b0;
  logic key_dn = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] q;
  logic rd_err;
  logic e;
  pdpc_req_t req;
  pdpc_drive_t drive;
  logic [15:0] status_word;
  int fail_count = 0;
  int checks = 0;
  logic [15:0] di [13] = '{16'h2004, 16'h2005, 16'h2006, 16'h2010, 16'h2011, 16'h2016,
    16'h2017, 16'h2019, 16'h201A, 16'h201B, 16'h201F, 16'h2022, 16'h2023};
  logic [31:0] dv [13] = '{32'h0, 32'h28, 32'h2, 32'h190, 32'h190, 32'h18B50, 32'h4B0,
    32'hC8, 32'h1E, 32'hC8, 32'hFA, 32'h1, 32'hC8};
  logic [15:0] ci [9] = '{16'h2012, 16'h2020, 16'h2021, 16'h2019, 16'h2018, 16'h2014,
    16'h201C, 16'h201D, 16'h201B};
  logic [31:0] cv [9] = '{32'h12C, 32'h3E8, 32'h3E8, 32'h1, 32'h11, 32'h22, 32'h33,
    32'h44, 32'h1};
  always #20 clk = ~clk;
  pdpc_core pdpc_core_inst (.clk(clk), .sys_rst(sys_rst), .req(req), .rd_data(rd_data),
    .rd_err(rd_err), .nv_load(nv_load), .enc_count(enc_count), .enc_tick(1'b0),
    .speed_meas(speed_meas), .speed_cmd(speed_cmd), .key_up(key_up), .key_dn(key_dn),
    .drive(drive), .status_word(status_word));
  pdpc_master pdpc_master_inst (.clk(clk), .rd_data(rd_data), .rd_err(rd_err), .req(req));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic [3:0] s = 4'h0);
    pdpc_master_inst.acc(1'b1, i, s, d, q, e);
  endtask : wr
  task automatic rdc(input logic [15:0] i, input logic [31:0] x,
    input logic [31:0] m = 32'hFFFFFFFF, input logic [3:0] s = 4'h0, input logic xe = 1'b0);
    pdpc_master_inst.acc(1'b0, i, s, 32'h0, q, e);
    chk(q & m, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rdc
  task automatic st(input logic [31:0] x, input logic [31:0] m);
    repeat (6) @(posedge clk);
    rdc(16'h2025, x, m);
  endtask : st
  task automatic dflt;
    for (int k = 0; k < 13; k++) begin
      rdc(di[k], dv[k]);
    end
    for (int k = 0; k < 10; k++) begin
      rdc(16'h2000, 32'h0, 32'hFFFFFFFF, k[3:0]);
    end
  endtask : dflt
  initial begin
    #4000000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    dflt();
    for (int k = 0; k < 10; k++) begin
      wr(16'h2000, 32'h1000 + k, k[3:0]);
      rdc(16'h2000, 32'h1000 + k, 32'hFFFFFFFF, k[3:0]);
    end
    rdc(16'h2000, 32'h0, 32'hFFFFFFFF, 4'hA, 1'b1);
    rdc(16'h2002, 32'h0, 32'hFFFFFFFF, 4'h0, 1'b1);
    for (int k = 4; k < 36; k++) begin
      if (!(k inside {[7:15], 21, 30})) begin
        wr(16'h2000 + k[15:0], 32'hA5C03C00 + k);
        rdc(16'h2000 + k[15:0], (k inside {4, 22, 23, 31}) ? 32'hA5C03C00 + k : 32'h3C00 + k);
      end
    end
    @(posedge clk) #1 nv_load = 1'b1;
    @(posedge clk) #1 nv_load = 1'b0;
    dflt();
    $display("test entries done");
    for (int k = 0; k < 9; k++) begin
      wr(ci[k], cv[k]);
    end
    wr(16'h2003, 32'h1388);
    rdc(16'h2003, 32'h1388);
    wr(16'h2004, 32'h64);
    rdc(16'h2003, 32'h13EC);
    wr(16'h2004, 32'h0);
    wr(16'h2001, 32'h18B51);
    st(32'h1000, 32'h1041);
    wr(16'h2001, 32'h4AF);
    st(32'h1000, 32'h1041);
    wr(16'h2001, 32'h1389);
    st(32'h1, 32'h1041);
    $display("test limits done");
    wr(16'h2001, 32'h1770);
    st(32'h40, 32'h1043);
    chk({16'h0, drive.speed_limit}, 32'h12C);
    chk({16'h0, drive.torque_limit}, 32'h11);
    chk({16'h0, drive.ramp_rate}, 32'h33);
    chk({30'h0, drive.dir_up, drive.run}, 32'h3);
    repeat (26000) @(posedge clk);
    chk({16'h0, drive.torque_limit}, 32'h22);
    wr(16'h2005, 32'h1);
    st(32'h42, 32'h43);
    wr(16'h2006, 32'h3E8);
    st(32'h1, 32'h41);
    $display("test run done");
    wr(16'h2006, 32'h2);
    wr(16'h2005, 32'h28);
    speed_cmd = 16'h0064;
    wr(16'h2001, 32'h1B58);
    repeat (26000) @(posedge clk);
    st(32'h20, 32'h60);
    $display("test stall done");
    speed_cmd = 16'h0000;
    wr(16'h2013, 32'h55);
    wr(16'h2022, 32'h5);
    wr(16'h2024, 32'h100);
    wr(16'h2024, 32'h0);
    st(32'h40, 32'h41);
    chk({16'h0, drive.speed_limit}, 32'h55);
    enc_count = 32'h00001002;
    st(32'h40, 32'h41);
    enc_count = 32'h00001005;
    st(32'h0, 32'h41);
    wr(16'h2023, 32'h0);
    key_dn = 1'b1;
    st(32'h40, 32'h41);
    chk({30'h0, drive.dir_up, drive.run}, 32'h1);
    key_dn = 1'b0;
    st(32'h0, 32'h41);
    $display("test manual done");
    wr(16'h2001, 32'h1388);
    st(32'h40, 32'h41);
    chk({31'h0, drive.dir_up}, 32'h0);
    enc_count = 32'h00000F06;
    st(32'h40, 32'h41);
    chk({16'h0, drive.ramp_rate}, 32'h44);
    chk({31'h0, drive.dir_up}, 32'h1);
    enc_count = 32'h00001000;
    st(32'h1, 32'h61);
    wr(16'h2011, 32'h320);
    rdc(16'h2003, 32'h2710);
    $display("test loop done");
    close_out();
  end
endmodule : test_positioning_drive_parameter_core
